// ===== core/ofc_cfg.svh
// Functional notes
// - With the address-include bit at one the 4-bit device address is added to the frame, at zero it is left out.
// - The 2-bit supply-alarm include field adds no flag, the high flag, the low flag, or both, for 00b, 01b, 10b and 11b.
// - The 2-bit input-alarm include field adds no flag, the high flag, the low flag, or both, for 00b, 01b, 10b and 11b.
// - With the range-include bit at one the 4-bit input range setting is added to the frame, at zero it is not.
// - With parity enabled two parity bits, result then frame, end the frame and make it two bits longer.
// - The result parity bit is even parity over the result position bits alone.
// - The frame parity bit is even parity over every frame bit except the result parity bit itself.
// - The result selector sends the conversion result for codes 0xxb, all zeros for 100b and all ones for 101b.
// - Selector code 110b sends alternating single zeros and ones, and 111b alternating pairs of them.
// - Reserved bits of the output frame control register ignore writes and always read as zero.
`ifndef OFC_CFG_SVH
`define OFC_CFG_SVH

`define OFC_ADDR_W         8
`define OFC_DATA_W         32
`define OFC_CTL_OFFSET     8'h10
`define OFC_STAT_OFFSET    8'h40

`define OFC_CTL_WR_MASK    32'h0000_7D0F
`define OFC_CTL_RESET      32'h0000_0000

`define OFC_BIT_ADDR_INC   14
`define OFC_BIT_SUP_HI     13
`define OFC_BIT_SUP_LO     12
`define OFC_BIT_IN_HI      11
`define OFC_BIT_IN_LO      10
`define OFC_BIT_RNG_INC    8
`define OFC_BIT_PARITY_APPEND_ENABLE     3
`define OFC_BIT_PAT_HI     2
`define OFC_BIT_PAT_LO     0

`define OFC_PAT_ZEROS      2'h0
`define OFC_PAT_ONES       2'h1
`define OFC_PAT_ALT1       2'h2
`define OFC_PAT_ALT2       2'h3

`define OFC_FIELD4_W       4
`define OFC_PARITY_W       2

`define OFC_STAT_CNT_W     16
`define OFC_STAT_LEN_LSB   16
`define OFC_STAT_FULL_BIT  24

`endif

// ===== core/ofc_pkg.sv
package ofc_pkg;

    typedef enum logic [1:0] {
        OFC_SUP_NONE = 2'h0,
        OFC_SUP_HIGH = 2'h1,
        OFC_SUP_LOW  = 2'h2,
        OFC_SUP_BOTH = 2'h3
    } ofc_flag_sel_t;

    typedef struct packed {
        logic          addr_inc;
        ofc_flag_sel_t supply_sel;
        ofc_flag_sel_t input_sel;
        logic          range_inc;
        logic          parity_en;
        logic [2:0]    pattern_sel;
    } ofc_ctl_t;

endpackage

// ===== core/ofc_stream_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ofc_stream_if #(
    parameter int W = 8
);
    logic [W-1:0] data;
    logic         valid;
    logic         ready;

    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

// ===== core/ofc_pattern_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "ofc_cfg.svh"
module ofc_pattern_gen
    import ofc_pkg::*;
#(
    parameter int RES_W = 14
) (
    input  wire logic [2:0]       pattern_sel,
    input  wire logic [RES_W-1:0] conv_data,
    output wire logic [RES_W-1:0] result_value
);
    logic [RES_W-1:0] alt1_pattern;
    logic [RES_W-1:0] alt2_pattern;

    // Bit zero of both patterns is a zero so the host can lock on the LSB end.
    genvar i;
    generate
        for (i = 0; i < RES_W; i++) begin : g_pat
            assign alt1_pattern[i] = 1'(i % 2);
            assign alt2_pattern[i] = 1'((i / 2) % 2);
        end
    endgenerate

    wire [1:0]       test_code = pattern_sel[1:0];
    wire [RES_W-1:0] test_value =
        (test_code == `OFC_PAT_ZEROS) ? {RES_W{1'b0}} :
        (test_code == `OFC_PAT_ONES)  ? {RES_W{1'b1}} :
        (test_code == `OFC_PAT_ALT1)  ? alt1_pattern  : alt2_pattern;

    assign result_value = pattern_sel[2] ? test_value : conv_data;
endmodule
`default_nettype wire

// ===== core/ofc_skid_buf.sv
`timescale 1ns/1ps
`default_nettype none
module ofc_skid_buf #(
    parameter int W = 8
) (
    input  wire logic core_clk,
    input  wire logic reset,
    ofc_stream_if.snk in_s,
    ofc_stream_if.src out_s,
    output logic      full
);
    logic [W-1:0] head_reg;
    logic [W-1:0] tail_reg;
    logic         valid_reg;
    logic         room_reg;

    wire push = in_s.valid & room_reg;
    wire pop  = valid_reg & out_s.ready;

    // Ready is the room flop itself, so the receiver's stall never reaches the source through gates.
    assign in_s.ready  = room_reg;
    assign out_s.data  = head_reg;
    assign out_s.valid = valid_reg;
    assign full        = ~room_reg;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            head_reg  <= '0;
            tail_reg  <= '0;
            valid_reg <= 1'b0;
            room_reg  <= 1'b1;
        end else if (push && (!valid_reg || pop)) begin
            head_reg  <= in_s.data;
            valid_reg <= 1'b1;
        end else if (push) begin
            tail_reg <= in_s.data;
            room_reg <= 1'b0;
        end else if (pop && !room_reg) begin
            head_reg <= tail_reg;
            room_reg <= 1'b1;
        end else if (pop) begin
            valid_reg <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== core/ofc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ofc_cfg.svh"
module ofc_top
    import ofc_pkg::*;
#(
    parameter int RES_W = 14
) (
    input  wire logic                      core_clk,
    input  wire logic                      reset,
    input  wire logic [`OFC_ADDR_W-1:0]    reg_addr,
    input  wire logic [`OFC_DATA_W-1:0]    reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic      [`OFC_DATA_W-1:0]    reg_rdata,
    input  wire logic [RES_W-1:0]          conv_data,
    input  wire logic                      conv_valid,
    output logic                           conv_ready,
    input  wire logic [`OFC_FIELD4_W-1:0]  dev_addr,
    input  wire logic                      supply_alarm_hi,
    input  wire logic                      supply_alarm_lo,
    input  wire logic                      input_alarm_hi,
    input  wire logic                      input_alarm_lo,
    input  wire logic [`OFC_FIELD4_W-1:0]  range_setting,
    output logic [RES_W+4*`OFC_FIELD4_W+`OFC_PARITY_W-1:0] frame_data,
    output logic [$clog2(RES_W+4*`OFC_FIELD4_W+`OFC_PARITY_W+1)-1:0] frame_len,
    output logic                           frame_valid,
    input  wire logic                      frame_ready
);
    localparam int FRAME_W = RES_W + 4 * `OFC_FIELD4_W + `OFC_PARITY_W;
    localparam int LEN_W   = $clog2(FRAME_W + 1);
    localparam int BUF_W   = FRAME_W + LEN_W;

    localparam logic [LEN_W-1:0] LEN_RES    = LEN_W'(RES_W);
    localparam logic [LEN_W-1:0] LEN_FIELD4 = LEN_W'(`OFC_FIELD4_W);
    localparam logic [LEN_W-1:0] LEN_PAR    = LEN_W'(`OFC_PARITY_W);

    // Control register and its decoded view.
    logic [`OFC_DATA_W-1:0] ctl_reg;
    logic [`OFC_DATA_W-1:0] ctl_next;
    logic [`OFC_STAT_CNT_W-1:0] frame_count_reg;
    logic [`OFC_DATA_W-1:0] rdata_reg;
    logic [`OFC_DATA_W-1:0] rdata_next;
    ofc_ctl_t ctl;
    logic buf_full;

    assign ctl.addr_inc    = ctl_reg[`OFC_BIT_ADDR_INC];
    assign ctl.supply_sel  = ofc_flag_sel_t'(ctl_reg[`OFC_BIT_SUP_HI:`OFC_BIT_SUP_LO]);
    assign ctl.input_sel   = ofc_flag_sel_t'(ctl_reg[`OFC_BIT_IN_HI:`OFC_BIT_IN_LO]);
    assign ctl.range_inc   = ctl_reg[`OFC_BIT_RNG_INC];
    assign ctl.parity_en   = ctl_reg[`OFC_BIT_PARITY_APPEND_ENABLE];
    assign ctl.pattern_sel = ctl_reg[`OFC_BIT_PAT_HI:`OFC_BIT_PAT_LO];

    // Register bus decode.
    wire ctl_hit  = (reg_addr == `OFC_CTL_OFFSET);
    wire stat_hit = (reg_addr == `OFC_STAT_OFFSET);
    wire ctl_wr   = reg_wr & ctl_hit;

    // Reserved bits are masked on write, so they can never read back as one.
    assign ctl_next = reg_wdata & `OFC_CTL_WR_MASK;

    // Result position value, either conversion data or a test pattern.
    logic [RES_W-1:0] result_value;

    ofc_pattern_gen #(
        .RES_W (RES_W)
    ) u_pattern (
        .pattern_sel  (ctl.pattern_sel),
        .conv_data    (conv_data),
        .result_value (result_value)
    );

    // Frame is built LSB-aligned; the first bit on the wire is bit frame_len-1.
    logic [FRAME_W-1:0] stage_res;
    logic [FRAME_W-1:0] stage_addr;
    logic [FRAME_W-1:0] stage_sup;
    logic [FRAME_W-1:0] stage_in;
    logic [FRAME_W-1:0] stage_rng;
    logic [FRAME_W-1:0] stage_par;
    logic [1:0]         sup_pair;
    logic [1:0]         in_pair;
    logic               res_parity;
    logic               frame_parity;

    assign stage_res  = FRAME_W'(result_value);
    assign stage_addr = ctl.addr_inc ? FRAME_W'({stage_res, dev_addr}) : stage_res;

    assign sup_pair  = {supply_alarm_hi, supply_alarm_lo};
    assign stage_sup =
        (ctl.supply_sel == OFC_SUP_NONE) ? stage_addr :
        (ctl.supply_sel == OFC_SUP_HIGH) ? FRAME_W'({stage_addr, supply_alarm_hi}) :
        (ctl.supply_sel == OFC_SUP_LOW)  ? FRAME_W'({stage_addr, supply_alarm_lo}) :
                                           FRAME_W'({stage_addr, sup_pair});

    assign in_pair  = {input_alarm_hi, input_alarm_lo};
    assign stage_in =
        (ctl.input_sel == OFC_SUP_NONE) ? stage_sup :
        (ctl.input_sel == OFC_SUP_HIGH) ? FRAME_W'({stage_sup, input_alarm_hi}) :
        (ctl.input_sel == OFC_SUP_LOW)  ? FRAME_W'({stage_sup, input_alarm_lo}) :
                                          FRAME_W'({stage_sup, in_pair});

    assign stage_rng = ctl.range_inc ? FRAME_W'({stage_in, range_setting}) : stage_in;

    // The parity covers the value actually sent, so test patterns carry valid parity too.
    assign res_parity   = ^result_value;
    assign frame_parity = ^stage_rng;
    assign stage_par    = ctl.parity_en ?
                          FRAME_W'({stage_rng, res_parity, frame_parity}) : stage_rng;

    // Frame length follows the enabled fields.
    wire [LEN_W-1:0] sup_len = LEN_W'(ctl.supply_sel[1]) + LEN_W'(ctl.supply_sel[0]);
    wire [LEN_W-1:0] in_len  = LEN_W'(ctl.input_sel[1]) + LEN_W'(ctl.input_sel[0]);
    wire [LEN_W-1:0] cfg_len = LEN_RES
                             + (ctl.addr_inc  ? LEN_FIELD4 : '0)
                             + sup_len
                             + in_len
                             + (ctl.range_inc ? LEN_FIELD4 : '0)
                             + (ctl.parity_en ? LEN_PAR : '0);

    wire [`OFC_DATA_W-1:0] stat_word =
        {{(`OFC_DATA_W - `OFC_STAT_FULL_BIT - 1){1'b0}}, buf_full,
         {(`OFC_STAT_FULL_BIT - `OFC_STAT_LEN_LSB - LEN_W){1'b0}}, cfg_len,
         frame_count_reg};

    assign rdata_next = !reg_rd ? '0 :
                        ctl_hit ? (ctl_reg & `OFC_CTL_WR_MASK) :
                        stat_hit ? stat_word : '0;

    // Two-entry buffer between the composer and the serializer.
    ofc_stream_if #(.W(BUF_W)) comp_s ();
    ofc_stream_if #(.W(BUF_W)) out_s ();

    assign comp_s.data  = {cfg_len, stage_par};
    assign comp_s.valid = conv_valid;
    assign out_s.ready  = frame_ready;

    ofc_skid_buf #(
        .W (BUF_W)
    ) u_buf (
        .core_clk (core_clk),
        .reset    (reset),
        .in_s     (comp_s),
        .out_s    (out_s),
        .full     (buf_full)
    );

    assign conv_ready  = comp_s.ready;
    assign frame_data  = out_s.data[FRAME_W-1:0];
    assign frame_len   = out_s.data[BUF_W-1:FRAME_W];
    assign frame_valid = out_s.valid;

    wire frame_taken = out_s.valid & frame_ready;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ctl_reg <= `OFC_CTL_RESET;
        end else if (ctl_wr) begin
            ctl_reg <= ctl_next;
        end
    end

    // The counter wraps; software takes differences between two reads.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            frame_count_reg <= '0;
        end else if (frame_taken) begin
            frame_count_reg <= frame_count_reg + 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;
endmodule
`default_nettype wire

// ===== dv/ofc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "ofc_cfg.svh"
module ofc_monitor
    import ofc_pkg::*;
#(
    parameter int RES_W = 14,
    parameter int FW    = RES_W + 18
) (
    input wire logic                     core_clk,
    input wire logic                     reset,
    input wire logic [7:0]               reg_addr,
    input wire logic [31:0]              reg_wdata,
    input wire logic                     reg_wr,
    input wire logic                     reg_rd,
    input wire logic [31:0]              reg_rdata,
    input wire logic [RES_W-1:0]         conv_data,
    input wire logic                     conv_valid,
    input wire logic                     conv_ready,
    input wire logic [3:0]               dev_addr,
    input wire logic                     supply_alarm_hi,
    input wire logic                     supply_alarm_lo,
    input wire logic                     input_alarm_hi,
    input wire logic                     input_alarm_lo,
    input wire logic [3:0]               range_setting,
    input wire logic [FW-1:0]            frame_data,
    input wire logic [$clog2(FW+1)-1:0]  frame_len,
    input wire logic                     frame_valid,
    input wire logic                     frame_ready
);
    logic [31:0] ctl_reg;
    logic [31:0] ctl_next;
    logic [7:0]  exp_len;
    logic        take_new;
    // A frame composed into an empty buffer shows the next cycle, so only those get the length, parity and pattern checks.
    assign take_new = conv_valid && conv_ready && !frame_valid;
    assign ctl_next = (reg_wr && reg_addr == `OFC_CTL_OFFSET) ? reg_wdata & `OFC_CTL_WR_MASK
                                                               : ctl_reg;
    assign exp_len = 8'(RES_W + 4 * ctl_reg[14] + ctl_reg[13] + ctl_reg[12] + ctl_reg[11]
                        + ctl_reg[10] + 4 * ctl_reg[8] + 2 * ctl_reg[3]);
    always_ff @(posedge core_clk or posedge reset)
        if (reset) ctl_reg <= '0;
        else ctl_reg <= ctl_next;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    property p_rd_idle; !reg_rd |=> reg_rdata == '0; endproperty
    property p_ctl_rd; reg_rd && reg_addr == `OFC_CTL_OFFSET |=> reg_rdata == $past(ctl_reg);
    endproperty
    property p_len; take_new |=> frame_valid && frame_len == $past(exp_len); endproperty
    property p_upper; frame_valid |-> (frame_data >> frame_len) == '0; endproperty
    property p_fpar; take_new && ctl_reg[3] |=> ^{frame_data[FW-1:2], frame_data[0]} == 1'b0;
    endproperty
    property p_rpar;
        take_new && ctl_reg[3] |=> ^(frame_data >> (frame_len - RES_W)) == frame_data[1];
    endproperty
    property p_pat;
        take_new && ctl_reg[2:1] == 2'h2 |=>
            (frame_data >> (frame_len - RES_W)) == ({FW{$past(ctl_reg[0])}} >> (FW - RES_W));
    endproperty
    property p_hold;
        frame_valid && !frame_ready |=> frame_valid && $stable(frame_data) && $stable(frame_len);
    endproperty

    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    a_ctl_rd: assert property (p_ctl_rd) else $error("control readback wrong");
    a_len: assert property (p_len) else $error("frame length wrong");
    a_upper: assert property (p_upper) else $error("bits above frame");
    a_fpar: assert property (p_fpar) else $error("frame parity wrong");
    a_rpar: assert property (p_rpar) else $error("result parity wrong");
    a_pat: assert property (p_pat) else $error("fixed pattern wrong");
    a_hold: assert property (p_hold) else $error("frame changed while stalled");

    c_stall: cover property (frame_valid && !frame_ready);
    c_full: cover property (!conv_ready);
    c_par: cover property (take_new && ctl_reg[3]);
endmodule
`default_nettype wire

// ===== dv/ofc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ofc_host_model (
    input wire logic  core_clk,
    input wire logic  reset,
    input wire logic  slow,
    output var logic  frame_ready
);
    int seed = 32'h3C81;
    // A slow host takes a frame one cycle in four, so the buffer fills and refuses.
    always @(posedge core_clk or posedge reset)
        if (reset) frame_ready <= 1'b0;
        else frame_ready <= slow ? ($random(seed) % 4 == 0) : 1'b1;
endmodule
`default_nettype wire

// ===== dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "ofc_cfg.svh"
module testbench;
    import ofc_pkg::*;
    logic core_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
    logic conv_valid = 1'b0, slow = 1'b0, conv_ready, frame_valid, frame_ready;
    logic [7:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0, ctl = '0, reg_rdata, frame_data;
    logic [13:0] conv_data = '0;
    logic [3:0] dev_addr = '0, flags = '0, range_setting = '0;
    logic [5:0] frame_len;
    logic [31:0] rdq[$];
    logic [37:0] fq[$];
    int error_cnt = 0, n_tests = 0, seed = 32'h3C81, nfr = 0, i, k;
    always #12.5 core_clk = ~core_clk;
    ofc_top #(.RES_W(14)) i_dut (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .conv_data(conv_data), .conv_valid(conv_valid), .conv_ready(conv_ready),
        .dev_addr(dev_addr), .supply_alarm_hi(flags[3]), .supply_alarm_lo(flags[2]),
        .input_alarm_hi(flags[1]), .input_alarm_lo(flags[0]), .range_setting(range_setting),
        .frame_data(frame_data), .frame_len(frame_len), .frame_valid(frame_valid),
        .frame_ready(frame_ready));
    ofc_host_model i_host (.core_clk(core_clk), .reset(reset), .slow(slow),
        .frame_ready(frame_ready));

    function automatic logic [37:0] mk(input logic [31:0] c, input logic [13:0] d,
                                       input logic [3:0] a, input logic [3:0] f,
                                       input logic [3:0] r);
        logic [31:0] v;
        logic        rp;
        case (c[2:0])
            3'h4: v = 32'h0;
            3'h5: v = 32'h3FFF;
            3'h6: v = 32'h2AAA;
            3'h7: v = 32'h0CCC;
            default: v = 32'(d);
        endcase
        rp = ^v;
        v = c[14] ? {v[27:0], a} : v;
        v = c[12] ? {v[30:0], f[3]} : v;
        v = c[13] ? {v[30:0], f[2]} : v;
        v = c[10] ? {v[30:0], f[1]} : v;
        v = c[11] ? {v[30:0], f[0]} : v;
        v = c[8] ? {v[27:0], r} : v;
        v = c[3] ? {v[29:0], rp, ^v} : v;
        return {6'(14 + 4 * c[14] + c[13] + c[12] + c[11] + c[10] + 4 * c[8] + 2 * c[3]), v};
    endfunction

    task automatic tally_and_finish();
        if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_frame(input logic [37:0] got, input logic [37:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        if (a == `OFC_CTL_OFFSET) ctl = d & `OFC_CTL_WR_MASK;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        reg_rd <= 1'b1;
        reg_addr <= a;
        rdq.push_back(exp);
        @(posedge core_clk);
        reg_rd <= 1'b0;
    endtask
    task automatic send();
        logic [13:0] d;
        logic [3:0]  a, f, r;
        int          n;
        d = 14'($random(seed));
        a = 4'($random(seed));
        f = 4'($random(seed));
        r = 4'($random(seed));
        conv_data <= d;
        dev_addr <= a;
        flags <= f;
        range_setting <= r;
        conv_valid <= 1'b1;
        n = 0;
        // The source holds its word while the buffer refuses.
        do begin
            @(posedge core_clk);
            n++;
        end while (!conv_ready && n < 100);
        if (!conv_ready) begin
            error_cnt++;
            tally_and_finish();
        end
        fq.push_back(mk(ctl, d, a, f, r));
        nfr++;
    endtask

    always @(posedge core_clk) begin
        rd_d <= reg_rd;
        if (rd_d) cmp_reg(reg_rdata, rdq.pop_front());
        if (frame_valid && frame_ready) cmp_frame({frame_len, frame_data}, fq.pop_front());
    end

    initial begin
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        rd(`OFC_CTL_OFFSET, 32'h0);
        wr(8'h24, 32'hFFFF_FFFF);
        rd(8'h24, 32'h0);
        send();
        conv_valid <= 1'b0;
        for (i = 0; i < 48; i++) begin
            slow <= i[1];
            wr(`OFC_CTL_OFFSET, ($random(seed) & 32'hFFFF_FFF8) | 32'(i % 8));
            rd(`OFC_CTL_OFFSET, ctl);
            repeat (3) send();
            conv_valid <= 1'b0;
        end
        for (k = 0; k < 500 && fq.size() > 0; k++) @(posedge core_clk);
        if (fq.size() > 0) error_cnt++;
        rd(`OFC_STAT_OFFSET, {10'h0, 6'(mk(ctl, 0, 0, 0, 0) >> 32), 16'(nfr)});
        repeat (2) @(posedge core_clk);
        tally_and_finish();
    end
endmodule

bind ofc_top ofc_monitor #(.RES_W(RES_W)) i_mon (.core_clk(core_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .conv_data(conv_data), .conv_valid(conv_valid),
    .conv_ready(conv_ready), .dev_addr(dev_addr), .supply_alarm_hi(supply_alarm_hi),
    .supply_alarm_lo(supply_alarm_lo), .input_alarm_hi(input_alarm_hi),
    .input_alarm_lo(input_alarm_lo), .range_setting(range_setting),
    .frame_data(frame_data), .frame_len(frame_len), .frame_valid(frame_valid),
    .frame_ready(frame_ready));
`default_nettype wire
